// File: cpd_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cpd_assertions (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // Register bus
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  // Drive
  input wire logic        DRIVE_PULSE,
  input wire logic        DRIVE_DIR,
  input wire logic        DRIVE_BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_pulse_single: assert property (DRIVE_PULSE |=> !DRIVE_PULSE)
    else $error("drive pulse too wide");
  a_idle_quiet: assert property (!DRIVE_BUSY && !$past(DRIVE_BUSY) |-> !DRIVE_PULSE)
    else $error("pulse while idle");
  a_dir_steady: assert property (DRIVE_BUSY && $past(DRIVE_BUSY) |-> $stable(DRIVE_DIR))
    else $error("direction moved in a run");
  // A run may only begin from a written command, one cycle into its response
  a_start_cause: assert property ($rose(DRIVE_BUSY) |-> $past(BVALID))
    else $error("run began without a command");
  a_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
    else $error("no write response");
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_rd_answer: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
    else $error("no read response");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_ar_refused: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while answering");
  c_start: cover property ($rose(DRIVE_BUSY));
  c_stop: cover property ($fell(DRIVE_BUSY));
  c_neg_pulse: cover property (DRIVE_PULSE && DRIVE_DIR);
endmodule
bind cpd_speed_ctrl cpd_assertions u_chk (.CLK, .RESETN, .AWVALID, .AWREADY, .WVALID,
  .WREADY, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA,
  .DRIVE_PULSE, .DRIVE_DIR, .DRIVE_BUSY);
`default_nettype wire

// File: cpd_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
module cpd_motor_model (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Drive from the block
  input  wire logic          pulse,
  input  wire logic          dir,
  // Sensor control; inv sets each line's idle level
  input  wire logic [2:0]    trip,
  input  wire logic [2:0]    inv,
  // Sensor lines and shaft position
  output logic [2:0]         halt_lines,
  output logic signed [31:0] pos
);
  // Lines 0 and 1 near-home and home, line 2 the encoder index
  assign halt_lines = trip ^ inv;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pos <= '0;
    else if (pulse)
      pos <= dir ? pos - 32'sd1 : pos + 32'sd1;
  end
endmodule
`default_nettype wire

// File: cpd_pkg.sv
package cpd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD_DATA   = 8'h00;
  localparam logic [7:0] OFS_COMMAND    = 8'h04;
  localparam logic [7:0] OFS_START_RATE = 8'h08;
  localparam logic [7:0] OFS_RAMP_UP    = 8'h0C;
  localparam logic [7:0] OFS_RAMP_DOWN  = 8'h10;
  localparam logic [7:0] OFS_RATE_STEP  = 8'h14;
  localparam logic [7:0] OFS_INPUT_CFG  = 8'h18;
  localparam logic [7:0] OFS_MODE_CFG   = 8'h1C;
  localparam logic [7:0] OFS_STATUS     = 8'h20;
  localparam logic [7:0] OFS_CUR_RATE   = 8'h24;
  localparam logic [7:0] OFS_TARGET_CNT = 8'h28;
  localparam logic [7:0] OFS_DRIVE_RATE = 8'h2C;

  // Command codes
  localparam logic [7:0] CMD_FIXED_POS  = 8'h50;
  localparam logic [7:0] CMD_CONT_POS   = 8'h52;
  localparam logic [7:0] CMD_CONT_NEG   = 8'h53;
  localparam logic [7:0] CMD_SET_RATE   = 8'h05;
  localparam logic [7:0] CMD_RATE_INC   = 8'h70;
  localparam logic [7:0] CMD_RATE_DEC   = 8'h71;
  localparam logic [7:0] CMD_DECEL_STOP = 8'h26;
  localparam logic [7:0] CMD_INST_STOP  = 8'h27;

  // Mode config field positions
  localparam int MODE_ASYM_BIT    = 1;
  localparam int MODE_SCURVE_BIT  = 2;
  localparam int MODE_TRI_DIS_BIT = 13;
  // Input config: enables in [2:0], active-high levels in [5:3]
  localparam int INCFG_EN_LSB  = 0;
  localparam int INCFG_LVL_LSB = 3;

  // Reset values
  localparam logic [15:0] RST_START_RATE = 16'h0010;
  localparam logic [15:0] RST_DRIVE_RATE = 16'h0010;
  localparam logic [15:0] RST_SLOPE      = 16'h0001;
  localparam logic [15:0] RST_STEP       = 16'h0000;
  localparam logic [15:0] RST_MODE_CFG   = 16'h0000;
  localparam logic [5:0]  RST_INPUT_CFG  = 6'h00;
  localparam logic [23:0] RST_TARGET_CNT = 24'h000000;

  // Ramp update interval
  localparam int CLK_PERIOD_NS  = 4;
  localparam int RAMP_TICK_NS   = 1000;
  localparam int RAMP_TICK_CYC  = RAMP_TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_TICK_LAST = 8'(RAMP_TICK_CYC - 1);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL} cpd_state_t;

endpackage

// File: cpd_speed_ctrl.sv
// Behaviour
// - Continuous drive pulses forever until a stop command or enabled halt input.
// - Two stop commands: ramped stop and instant stop.
// - Three halt inputs, each enable and level; ramped stop, instant at start rate.
// - Code 52h starts positive continuous drive, 53h negative.
// - Speed may change anytime in continuous drive, by rewrite or inc/dec.
// - S-curve: speed change during a ramp is ignored.
// - Fixed-count symmetric linear or constant speed allows mid-move rate change.
// - Fixed-count asymmetric or S-curve refuses any rate change.
// - Command 05h sets drive rate at once; ramps toward it when ramping.
// - 70h raises, 71h lowers the drive rate by the preloaded step.
// - Ramped continuous drive performs ramped stop on an enabled halt.
// - Constant-speed drive stops at once on an enabled halt.
// - Drive rate below start rate: no ramp, instant stopping.
// - Symmetric or asymmetric slopes for linear and S-curve profiles; here every ramp is linear whatever the S-curve bit.
// - Triangle prevention on after reset, off when its mode bit is 1.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cpd_speed_ctrl (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // AXI4-Lite write
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // External halt inputs
  input  wire logic        EXT_HALT_LINE_0,
  input  wire logic        EXT_HALT_LINE_1,
  input  wire logic        EXT_HALT_LINE_2,
  // Drive outputs
  output logic             DRIVE_PULSE,
  output logic             DRIVE_DIR,
  output logic             DRIVE_BUSY
);

  function automatic logic [15:0] rate_up(input logic [15:0] v, input logic [15:0] s,
                                          input logic [15:0] lim);
    logic [16:0] sum;
    sum = {1'b0, v} + {1'b0, s};
    rate_up = (sum >= {1'b0, lim}) ? lim : sum[15:0];
  endfunction

  function automatic logic [15:0] rate_dn(input logic [15:0] v, input logic [15:0] s,
                                          input logic [15:0] lim);
    rate_dn = (v <= lim || (v - lim) <= s) ? lim : 16'(v - s);
  endfunction

  // Bus state
  logic [7:0]  aw_addr_ff, nxt_aw_addr;
  logic        aw_have_ff, nxt_aw_have;
  logic [31:0] w_data_ff, nxt_w_data;
  logic        w_have_ff, nxt_w_have;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [31:0] cmd_data_ff, nxt_cmd_data;
  logic [15:0] start_rate_ff, nxt_start_rate;
  logic [15:0] ramp_up_slope_ff, nxt_ramp_up_slope;
  logic [15:0] ramp_down_slope_ff, nxt_ramp_down_slope;
  logic [15:0] rate_step_ff, nxt_rate_step;
  logic [5:0]  input_config_reg_ff, nxt_input_config_reg;
  logic [15:0] mode_config_reg_ff, nxt_mode_config_reg;
  logic [23:0] target_pulse_count_ff, nxt_target_pulse_count;
  logic        cmd_go_ff, nxt_cmd_go;
  logic [7:0]  cmd_code_ff, nxt_cmd_code;

  // Motion state
  cpd_pkg::cpd_state_t state_ff, nxt_state;
  logic [15:0] drive_rate_ff, nxt_drive_rate;
  logic [15:0] cur_rate_ff, nxt_cur_rate;
  logic [27:0] phase_ff, nxt_phase;
  logic [7:0]  tick_ff, nxt_tick;
  logic        dir_ff, nxt_dir;
  logic        const_ff, nxt_const;
  logic        fixed_ff, nxt_fixed;
  logic        freeze_ff, nxt_freeze;
  logic [23:0] out_cnt_ff, nxt_out_cnt;
  logic [23:0] acc_cnt_ff, nxt_acc_cnt;
  logic        pulse_ff, nxt_pulse;

  logic [2:0]  halt_sync;
  logic        halt_hit;
  logic        wr_fire;
  logic        asym;
  logic        scurve;
  logic        ramping;

  cpd_sync #(.W(3)) u_halt_sync (
    .clk   (CLK),
    .rst_n (RESETN),
    .din   ({EXT_HALT_LINE_2, EXT_HALT_LINE_1, EXT_HALT_LINE_0}),
    .dout  (halt_sync)
  );

  assign asym   = mode_config_reg_ff[cpd_pkg::MODE_ASYM_BIT];
  assign scurve = mode_config_reg_ff[cpd_pkg::MODE_SCURVE_BIT];
  // Halt line is active when its level matches the configured active level
  assign halt_hit = |(input_config_reg_ff[cpd_pkg::INCFG_EN_LSB +: 3] &
                      ~(halt_sync ^ input_config_reg_ff[cpd_pkg::INCFG_LVL_LSB +: 3]));
  assign ramping = (state_ff == cpd_pkg::ST_DECEL) ||
                   (state_ff == cpd_pkg::ST_RUN && !const_ff && cur_rate_ff != drive_rate_ff &&
                    !freeze_ff);
  assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;

  // Bus slave and parameter registers
  always_comb begin
    nxt_aw_addr = aw_addr_ff;
    nxt_aw_have = aw_have_ff;
    nxt_w_data = w_data_ff;
    nxt_w_have = w_have_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_cmd_data = cmd_data_ff;
    nxt_start_rate = start_rate_ff;
    nxt_ramp_up_slope = ramp_up_slope_ff;
    nxt_ramp_down_slope = ramp_down_slope_ff;
    nxt_rate_step = rate_step_ff;
    nxt_input_config_reg = input_config_reg_ff;
    nxt_mode_config_reg = mode_config_reg_ff;
    nxt_target_pulse_count = target_pulse_count_ff;
    nxt_cmd_go = 1'b0;
    nxt_cmd_code = cmd_code_ff;
    if (AWVALID && !aw_have_ff) begin
      nxt_aw_addr = AWADDR;
      nxt_aw_have = 1'b1;
    end
    if (WVALID && !w_have_ff) begin
      nxt_w_data = WDATA;
      nxt_w_have = 1'b1;
    end
    if (BVALID && BREADY) begin
      nxt_bvalid = 1'b0;
    end
    // Byte strobes are ignored: every field is written as a whole word
    if (wr_fire) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = cpd_pkg::RESP_OKAY;
      if (aw_addr_ff == cpd_pkg::OFS_CMD_DATA) begin
        nxt_cmd_data = w_data_ff;
      end else if (aw_addr_ff == cpd_pkg::OFS_COMMAND) begin
        nxt_cmd_go = 1'b1;
        nxt_cmd_code = w_data_ff[7:0];
      end else if (aw_addr_ff == cpd_pkg::OFS_START_RATE) begin
        nxt_start_rate = w_data_ff[15:0];
      end else if (aw_addr_ff == cpd_pkg::OFS_RAMP_UP) begin
        nxt_ramp_up_slope = w_data_ff[15:0];
      end else if (aw_addr_ff == cpd_pkg::OFS_RAMP_DOWN) begin
        nxt_ramp_down_slope = w_data_ff[15:0];
      end else if (aw_addr_ff == cpd_pkg::OFS_RATE_STEP) begin
        nxt_rate_step = w_data_ff[15:0];
      end else if (aw_addr_ff == cpd_pkg::OFS_INPUT_CFG) begin
        nxt_input_config_reg = w_data_ff[5:0];
      end else if (aw_addr_ff == cpd_pkg::OFS_MODE_CFG) begin
        nxt_mode_config_reg = w_data_ff[15:0];
      end else if (aw_addr_ff == cpd_pkg::OFS_TARGET_CNT) begin
        nxt_target_pulse_count = w_data_ff[23:0];
      end else if (aw_addr_ff == cpd_pkg::OFS_STATUS || aw_addr_ff == cpd_pkg::OFS_CUR_RATE ||
                   aw_addr_ff == cpd_pkg::OFS_DRIVE_RATE) begin
        nxt_bresp = cpd_pkg::RESP_OKAY;
      end else begin
        nxt_bresp = cpd_pkg::RESP_SLVERR;
      end
    end
    if (RVALID && RREADY) begin
      nxt_rvalid = 1'b0;
    end
    if (ARVALID && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = cpd_pkg::RESP_OKAY;
      nxt_rdata = 32'h00000000;
      if (ARADDR == cpd_pkg::OFS_CMD_DATA) begin
        nxt_rdata = cmd_data_ff;
      end else if (ARADDR == cpd_pkg::OFS_COMMAND) begin
        nxt_rdata = {24'h000000, cmd_code_ff};
      end else if (ARADDR == cpd_pkg::OFS_START_RATE) begin
        nxt_rdata = {16'h0000, start_rate_ff};
      end else if (ARADDR == cpd_pkg::OFS_RAMP_UP) begin
        nxt_rdata = {16'h0000, ramp_up_slope_ff};
      end else if (ARADDR == cpd_pkg::OFS_RAMP_DOWN) begin
        nxt_rdata = {16'h0000, ramp_down_slope_ff};
      end else if (ARADDR == cpd_pkg::OFS_RATE_STEP) begin
        nxt_rdata = {16'h0000, rate_step_ff};
      end else if (ARADDR == cpd_pkg::OFS_INPUT_CFG) begin
        nxt_rdata = {26'h0000000, input_config_reg_ff};
      end else if (ARADDR == cpd_pkg::OFS_MODE_CFG) begin
        nxt_rdata = {16'h0000, mode_config_reg_ff};
      end else if (ARADDR == cpd_pkg::OFS_STATUS) begin
        nxt_rdata = {25'h0000000, halt_sync, ramping, fixed_ff, dir_ff,
                     state_ff != cpd_pkg::ST_IDLE};
      end else if (ARADDR == cpd_pkg::OFS_CUR_RATE) begin
        nxt_rdata = {16'h0000, cur_rate_ff};
      end else if (ARADDR == cpd_pkg::OFS_TARGET_CNT) begin
        nxt_rdata = {8'h00, target_pulse_count_ff};
      end else if (ARADDR == cpd_pkg::OFS_DRIVE_RATE) begin
        nxt_rdata = {16'h0000, drive_rate_ff};
      end else begin
        nxt_rresp = cpd_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_addr_ff <= 8'h00;
      aw_have_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= cpd_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= cpd_pkg::RESP_OKAY;
      cmd_data_ff <= 32'h00000000;
      start_rate_ff <= cpd_pkg::RST_START_RATE;
      ramp_up_slope_ff <= cpd_pkg::RST_SLOPE;
      ramp_down_slope_ff <= cpd_pkg::RST_SLOPE;
      rate_step_ff <= cpd_pkg::RST_STEP;
      input_config_reg_ff <= cpd_pkg::RST_INPUT_CFG;
      mode_config_reg_ff <= cpd_pkg::RST_MODE_CFG;
      target_pulse_count_ff <= cpd_pkg::RST_TARGET_CNT;
      cmd_go_ff <= 1'b0;
      cmd_code_ff <= 8'h00;
    end else begin
      aw_addr_ff <= nxt_aw_addr;
      aw_have_ff <= nxt_aw_have;
      w_data_ff <= nxt_w_data;
      w_have_ff <= nxt_w_have;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      cmd_data_ff <= nxt_cmd_data;
      start_rate_ff <= nxt_start_rate;
      ramp_up_slope_ff <= nxt_ramp_up_slope;
      ramp_down_slope_ff <= nxt_ramp_down_slope;
      rate_step_ff <= nxt_rate_step;
      input_config_reg_ff <= nxt_input_config_reg;
      mode_config_reg_ff <= nxt_mode_config_reg;
      target_pulse_count_ff <= nxt_target_pulse_count;
      cmd_go_ff <= nxt_cmd_go;
      cmd_code_ff <= nxt_cmd_code;
    end
  end

  assign AWREADY = !aw_have_ff;
  assign WREADY  = !w_have_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = !rvalid_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = rdata_ff;
  assign RRESP   = rresp_ff;

  // Motion control
  always_comb begin
    logic        rate_ok;
    logic        tick;
    logic [28:0] acc;
    logic [15:0] dn_slope;
    logic [15:0] goal;
    logic [23:0] remain;
    rate_ok = 1'b0;
    tick = 1'b0;
    acc = 29'h00000000;
    dn_slope = asym ? ramp_down_slope_ff : ramp_up_slope_ff;
    goal = 16'h0000;
    remain = 24'h000000;
    nxt_state = state_ff;
    nxt_drive_rate = drive_rate_ff;
    nxt_cur_rate = cur_rate_ff;
    nxt_phase = phase_ff;
    nxt_tick = tick_ff;
    nxt_dir = dir_ff;
    nxt_const = const_ff;
    nxt_fixed = fixed_ff;
    nxt_freeze = freeze_ff;
    nxt_out_cnt = out_cnt_ff;
    nxt_acc_cnt = acc_cnt_ff;
    nxt_pulse = 1'b0;
    // Rate changes refused while an S-curve ramps or an asymmetric or S-curve fixed move runs
    rate_ok = (state_ff == cpd_pkg::ST_IDLE) ||
              (!(scurve && ramping) && !(fixed_ff && (asym || scurve)));
    if (state_ff != cpd_pkg::ST_IDLE) begin
      tick = (tick_ff == cpd_pkg::RAMP_TICK_LAST);
      nxt_tick = tick ? 8'h00 : 8'(tick_ff + 8'h01);
      acc = {1'b0, phase_ff} + {13'h0000, cur_rate_ff};
      nxt_phase = acc[27:0];
      nxt_pulse = acc[28];
      if (acc[28]) begin
        nxt_out_cnt = 24'(out_cnt_ff + 24'h000001);
        if (cur_rate_ff < drive_rate_ff && !const_ff) begin
          nxt_acc_cnt = 24'(acc_cnt_ff + 24'h000001);
        end
      end
      remain = 24'(target_pulse_count_ff - nxt_out_cnt);
    end
    case (state_ff)
      cpd_pkg::ST_IDLE: begin
        nxt_phase = 28'h0000000;
        nxt_tick = 8'h00;
      end
      cpd_pkg::ST_RUN: begin
        goal = freeze_ff ? cur_rate_ff : drive_rate_ff;
        if (const_ff) begin
          nxt_cur_rate = drive_rate_ff;
        end else if (tick && cur_rate_ff < goal) begin
          nxt_cur_rate = rate_up(cur_rate_ff, ramp_up_slope_ff, goal);
        end else if (tick && cur_rate_ff > goal) begin
          nxt_cur_rate = rate_dn(cur_rate_ff, dn_slope, goal);
        end
        if (fixed_ff && !const_ff && !asym && !scurve) begin
          // Triangle prevention: hold speed once ramp pulses reach a quarter of the move
          if (!mode_config_reg_ff[cpd_pkg::MODE_TRI_DIS_BIT] &&
              {acc_cnt_ff, 2'b00} >= {2'b00, target_pulse_count_ff}) begin
            nxt_freeze = 1'b1;
          end
          if (remain <= acc_cnt_ff) begin
            nxt_state = cpd_pkg::ST_DECEL;
          end
        end
      end
      cpd_pkg::ST_DECEL: begin
        if (tick) begin
          nxt_cur_rate = rate_dn(cur_rate_ff, dn_slope, start_rate_ff);
        end
        if (!fixed_ff && cur_rate_ff <= start_rate_ff) begin
          nxt_state = cpd_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = cpd_pkg::ST_IDLE;
      end
    endcase
    if (state_ff != cpd_pkg::ST_IDLE && fixed_ff && nxt_out_cnt >= target_pulse_count_ff) begin
      nxt_state = cpd_pkg::ST_IDLE;
    end
    if (state_ff != cpd_pkg::ST_IDLE && halt_hit) begin
      if (const_ff || cur_rate_ff <= start_rate_ff) begin
        nxt_state = cpd_pkg::ST_IDLE;
      end else begin
        nxt_state = cpd_pkg::ST_DECEL;
      end
    end
    if (cmd_go_ff) begin
      case (cmd_code_ff)
        cpd_pkg::CMD_CONT_POS, cpd_pkg::CMD_CONT_NEG, cpd_pkg::CMD_FIXED_POS: begin
          if (state_ff == cpd_pkg::ST_IDLE) begin
            nxt_state = cpd_pkg::ST_RUN;
            nxt_dir = (cmd_code_ff == cpd_pkg::CMD_CONT_NEG);
            nxt_fixed = (cmd_code_ff == cpd_pkg::CMD_FIXED_POS);
            nxt_const = drive_rate_ff < start_rate_ff;
            nxt_cur_rate = (drive_rate_ff < start_rate_ff) ? drive_rate_ff : start_rate_ff;
            nxt_freeze = 1'b0;
            nxt_out_cnt = 24'h000000;
            nxt_acc_cnt = 24'h000000;
          end
        end
        cpd_pkg::CMD_SET_RATE: begin
          if (rate_ok) begin
            nxt_drive_rate = cmd_data_ff[15:0];
          end
        end
        cpd_pkg::CMD_RATE_INC: begin
          if (rate_ok) begin
            nxt_drive_rate = rate_up(drive_rate_ff, rate_step_ff, 16'hFFFF);
          end
        end
        cpd_pkg::CMD_RATE_DEC: begin
          if (rate_ok) begin
            nxt_drive_rate = rate_dn(drive_rate_ff, rate_step_ff, 16'h0000);
          end
        end
        cpd_pkg::CMD_DECEL_STOP: begin
          if (state_ff != cpd_pkg::ST_IDLE) begin
            nxt_state = (const_ff || cur_rate_ff <= start_rate_ff) ?
                        cpd_pkg::ST_IDLE : cpd_pkg::ST_DECEL;
            nxt_fixed = 1'b0;
          end
        end
        cpd_pkg::CMD_INST_STOP: begin
          nxt_state = cpd_pkg::ST_IDLE;
        end
        default: begin
          nxt_state = nxt_state;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= cpd_pkg::ST_IDLE;
      drive_rate_ff <= cpd_pkg::RST_DRIVE_RATE;
      cur_rate_ff <= 16'h0000;
      phase_ff <= 28'h0000000;
      tick_ff <= 8'h00;
      dir_ff <= 1'b0;
      const_ff <= 1'b0;
      fixed_ff <= 1'b0;
      freeze_ff <= 1'b0;
      out_cnt_ff <= 24'h000000;
      acc_cnt_ff <= 24'h000000;
      pulse_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      drive_rate_ff <= nxt_drive_rate;
      cur_rate_ff <= nxt_cur_rate;
      phase_ff <= nxt_phase;
      tick_ff <= nxt_tick;
      dir_ff <= nxt_dir;
      const_ff <= nxt_const;
      fixed_ff <= nxt_fixed;
      freeze_ff <= nxt_freeze;
      out_cnt_ff <= nxt_out_cnt;
      acc_cnt_ff <= nxt_acc_cnt;
      pulse_ff <= nxt_pulse;
    end
  end

  assign DRIVE_PULSE = pulse_ff;
  assign DRIVE_DIR   = dir_ff;
  assign DRIVE_BUSY  = (state_ff != cpd_pkg::ST_IDLE);

endmodule
`default_nettype wire

// File: cpd_speed_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module continuous_pulse_drive_speed_ctrl_tb_top;
  logic        CLK, RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic        DRIVE_PULSE, DRIVE_DIR, DRIVE_BUSY;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [1:0]  BRESP, RRESP;
  logic [2:0]  trip, inv, halt;
  logic [33:0] exq[$], ex;
  logic [15:0] d, s;
  logic signed [31:0] pos;
  int          miscompares, checked, seed;
  cpd_speed_ctrl dut (.CLK, .RESETN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hF),
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA,
    .RRESP, .RVALID, .RREADY, .EXT_HALT_LINE_0(halt[0]), .EXT_HALT_LINE_1(halt[1]),
    .EXT_HALT_LINE_2(halt[2]), .DRIVE_PULSE, .DRIVE_DIR, .DRIVE_BUSY);
  cpd_motor_model u_motor (.clk(CLK), .rst_n(RESETN), .pulse(DRIVE_PULSE), .dir(DRIVE_DIR),
    .trip(trip), .inv(inv), .halt_lines(halt), .pos(pos));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic expire;
    miscompares++;
    $display("mismatch at %0t: got %0h expected %0h", $time, 0, 1);
    end_of_test;
  endtask
  // Ready is raised only after valid shows, so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er = cpd_pkg::RESP_OKAY);
    int   n;
    logic aw, w, b;
    exq.push_back({er, 32'h0});
    {AWADDR, WDATA} <= {a, v};
    {AWVALID, WVALID} <= 2'b11;
    for (n = 0; n < 50; n++) begin
      @(negedge CLK);
      {aw, w, b} = {AWREADY, WREADY, BVALID};
      @(posedge CLK);
      if (aw && AWVALID) AWVALID <= 1'b0;
      if (w && WVALID) WVALID <= 1'b0;
      if (b && BREADY) break;
      if (b) BREADY <= 1'b1;
    end
    BREADY <= 1'b0;
    if (n == 50) expire;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int   n;
    logic ar, r;
    exq.push_back({cpd_pkg::RESP_OKAY, e});
    ARADDR <= a;
    ARVALID <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge CLK);
      {ar, r} = {ARREADY, RVALID};
      @(posedge CLK);
      if (ar) ARVALID <= 1'b0;
      if (r && RREADY) break;
      if (r) RREADY <= 1'b1;
    end
    RREADY <= 1'b0;
    if (n == 50) expire;
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(cpd_pkg::OFS_COMMAND, {24'h0, c});
  endtask
  task automatic setrate(input logic [15:0] r);
    wr(cpd_pkg::OFS_CMD_DATA, {16'h0, r});
    cmd(cpd_pkg::CMD_SET_RATE);
  endtask
  task automatic waitfor(input logic sel, input logic v, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge CLK);
      if ((sel ? DRIVE_PULSE : DRIVE_BUSY) === v) break;
    end
    @(posedge CLK);
    if (n == lim) expire;
  endtask
  task automatic busy_is(input logic v, input int cyc);
    repeat (cyc) @(negedge CLK);
    `CHK(DRIVE_BUSY, v)
    @(posedge CLK);
  endtask
  always @(negedge CLK) begin
    if ((BVALID && BREADY) || (RVALID && RREADY)) begin
      ex = exq.pop_front();
      if (BVALID)
        `CHK({BRESP, 32'h0}, ex)
      else
        `CHK({RRESP, RDATA}, ex)
    end
  end
  initial begin
    seed = 32'h22F30C0F;
    {RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY, trip, inv} = '0;
    {AWADDR, ARADDR, WDATA, miscompares, checked} = '0;
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    rd(cpd_pkg::OFS_START_RATE, cpd_pkg::RST_START_RATE);
    rd(cpd_pkg::OFS_DRIVE_RATE, cpd_pkg::RST_DRIVE_RATE);
    rd(cpd_pkg::OFS_RAMP_DOWN, cpd_pkg::RST_SLOPE);
    rd(cpd_pkg::OFS_RATE_STEP, cpd_pkg::RST_STEP);
    rd(cpd_pkg::OFS_MODE_CFG, cpd_pkg::RST_MODE_CFG);
    rd(cpd_pkg::OFS_STATUS, 32'h0);
    wr(8'h30, 32'h0, cpd_pkg::RESP_SLVERR);
    $display("done: reset values");
    d = 16'($random(seed)) & 16'h7FFF;
    s = {8'h0, 8'($random(seed))};
    setrate(d);
    rd(cpd_pkg::OFS_DRIVE_RATE, {16'h0, d});
    wr(cpd_pkg::OFS_RATE_STEP, {16'h0, s});
    cmd(cpd_pkg::CMD_RATE_INC);
    rd(cpd_pkg::OFS_DRIVE_RATE, d + s);
    cmd(cpd_pkg::CMD_RATE_DEC);
    busy_is(1'b0, 1);
    $display("done: idle rate commands");
    wr(cpd_pkg::OFS_START_RATE, 32'hFFFF);
    setrate(16'hF000);
    wr(cpd_pkg::OFS_INPUT_CFG, 32'h24);
    cmd(cpd_pkg::CMD_CONT_NEG);
    waitfor(1'b0, 1'b1, 10);
    rd(cpd_pkg::OFS_CUR_RATE, 32'hF000);
    trip <= 3'b001;
    busy_is(1'b1, 8);
    waitfor(1'b1, 1'b1, 5000);
    busy_is(1'b1, 1);
    `CHK(pos, -32'sd1)
    trip <= 3'b100;
    waitfor(1'b0, 1'b0, 4);
    trip <= 3'b000;
    $display("done: constant speed halt");
    wr(cpd_pkg::OFS_START_RATE, 32'h100);
    wr(cpd_pkg::OFS_RAMP_UP, 32'h800);
    setrate(16'h2000);
    wr(cpd_pkg::OFS_INPUT_CFG, 32'h01);
    inv <= 3'b001;
    cmd(cpd_pkg::CMD_CONT_POS);
    waitfor(1'b0, 1'b1, 10);
    repeat (1200) @(posedge CLK);
    rd(cpd_pkg::OFS_CUR_RATE, 32'h2000);
    setrate(16'h1000);
    repeat (600) @(posedge CLK);
    rd(cpd_pkg::OFS_CUR_RATE, 32'h1000);
    wr(cpd_pkg::OFS_RATE_STEP, 32'h400);
    cmd(cpd_pkg::CMD_RATE_INC);
    repeat (300) @(posedge CLK);
    rd(cpd_pkg::OFS_CUR_RATE, 32'h1400);
    cmd(cpd_pkg::CMD_CONT_NEG);
    trip <= 3'b001;
    busy_is(1'b1, 6);
    `CHK(DRIVE_DIR, 1'b0)
    waitfor(1'b0, 1'b0, 1500);
    trip <= 3'b000;
    $display("done: ramped drive and override");
    for (int i = 0; i < 2; i++) begin
      cmd(cpd_pkg::CMD_CONT_POS);
      waitfor(1'b0, 1'b1, 10);
      repeat (600) @(posedge CLK);
      cmd(i ? cpd_pkg::CMD_INST_STOP : cpd_pkg::CMD_DECEL_STOP);
      if (i == 0)
        busy_is(1'b1, 4);
      waitfor(1'b0, 1'b0, i ? 6 : 1500);
    end
    wr(cpd_pkg::OFS_TARGET_CNT, 32'h1);
    wr(cpd_pkg::OFS_MODE_CFG, 32'h2000);
    cmd(cpd_pkg::CMD_FIXED_POS);
    setrate(16'hFFFF);
    waitfor(1'b0, 1'b0, 9999);
    $display("done: stop commands");
    end_of_test;
  end
endmodule
`default_nettype wire

// File: cpd_sync.sv
`timescale 1ns/10ps
`default_nettype none
module cpd_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule
`default_nettype wire
